/* design/scfc_frame_check.sv */
// Frame checking and register layer of a 32-bit serial slave.
// Assumes the host keeps select low for three system clocks before the first
// serial clock edge and high for three system clocks between frames.
`timescale 1ns/100ps

module scfc_frame_check
  import scfc_pkg::*;
(
  // System side
  input wire logic clock,
  input wire logic reset,
  input wire scfc_mode_t device_mode,
  input wire logic [NUM_STAT-1:0][15:0] stat_event,
  // Device pins
  input wire logic device_reset_line_n,
  input wire logic crc_enable_strap,
  // Serial link
  input wire logic spi_clock,
  input wire logic csn_n,
  input wire logic sdi,
  output logic sdo_o,
  output logic sdo_oe,
  // Results
  output scfc_cfg_write_t cfg_write,
  output logic frame_error
);

  ////////////////////////////////////////////////////////////////////////////
  // System domain.

  scfc_sys_t s_q;
  scfc_sys_t s_d;
  scfc_shift_t l_q;
  scfc_shift_t l_d;
  scfc_snap_t n_q;
  scfc_snap_t n_d;
  scfc_out_t p_q;
  scfc_out_t p_d;

  logic fall;
  logic rise;
  logic zero_clk;
  logic frame_bad;
  logic crc_ok;
  logic allowed;
  logic [6:0] addr;
  logic [15:0] data;
  logic [2:0] sidx;
  logic [7:0] status8;

  always_comb begin
    s_d = s_q;
    fall = !s_q.csn_s && s_q.csn_p;
    rise = s_q.csn_s && !s_q.csn_p;
    zero_clk = (n_q.seq == s_q.last_seq);
    frame_bad = 1'b0;
    crc_ok = 1'b0;
    allowed = 1'b0;
    addr = n_q.word[6:0];
    data = n_q.word[23:8];
    sidx = 3'(addr - STAT_BASE);
    s_d.csn_m = csn_n;
    s_d.csn_s = s_q.csn_m;
    s_d.csn_p = s_q.csn_s;
    s_d.sclk_m = spi_clock;
    s_d.sclk_s = s_q.sclk_m;
    s_d.rstl_m = device_reset_line_n;
    s_d.rstl_s = s_q.rstl_m;
    s_d.crcen_m = crc_enable_strap;
    s_d.crcen_s = s_q.crcen_m;
    s_d.cfg.valid = 1'b0;
    s_d.spi_on = (device_mode == MODE_INIT) || (device_mode == MODE_NORMAL)
      || (device_mode == MODE_STOP);
    for (int i = 0; i < NUM_STAT; i++) begin
      s_d.stat[i] = s_q.stat[i] | stat_event[i];
    end
    if (fall) begin
      s_d.frame_rst = !s_q.rstl_s;
      s_d.clk_fall_err = s_q.sclk_s;
    end else if (!s_q.csn_s && !s_q.rstl_s) begin
      s_d.frame_rst = 1'b1;
    end
    if (rise) begin
      s_d.last_seq = n_q.seq;
      // A frame seen while the link is off is dropped without a trace.
      if (s_q.spi_on) begin
        frame_bad = (!zero_clk && n_q.cnt != FRAME_CLOCKS)
          || s_q.clk_fall_err || s_q.sclk_s
          || s_q.frame_rst || !s_q.rstl_s;
        s_d.err = frame_bad;
        if (!frame_bad && !zero_clk) begin
          crc_ok = s_q.crcen_s ? (n_q.word[31:24] == scfc_crc8(n_q.word[23:0]))
            : (n_q.word[31:24] == FILLER_RX);
          if (!crc_ok && !(addr == DEV_STAT_ADDR && !n_q.word[7])) begin
            s_d.stat[DEV_STAT_IDX][CRC_FAIL_BIT] = 1'b1;
          end else if (n_q.word[7] && !addr[6]) begin
            allowed = (device_mode != MODE_STOP)
              || (addr == MODE_CTRL_ADDR && data[2:0] == MODE_REQ_NORMAL)
              || (addr == WDOG_CTRL_ADDR);
            if (allowed) begin
              // In stop mode only the mode field of a mode write is taken.
              if (device_mode == MODE_STOP && addr == MODE_CTRL_ADDR) begin
                s_d.ctrl[addr[5:0]] = {s_q.ctrl[addr[5:0]][15:3], data[2:0]};
              end else begin
                s_d.ctrl[addr[5:0]] = data;
              end
              s_d.cfg.valid = 1'b1;
              s_d.cfg.addr = addr;
              s_d.cfg.data = s_d.ctrl[addr[5:0]];
            end else begin
              s_d.stat[DEV_STAT_IDX][CMD_REJECT_BIT] = 1'b1;
            end
          end else if (n_q.word[7] && addr >= STAT_BASE && (addr - STAT_BASE) < 7'(NUM_STAT)) begin
            // Only bits the host has seen are cleared, so new events survive.
            s_d.stat[sidx] = (s_q.stat[sidx] & ~s_q.shadow[sidx]) | stat_event[sidx];
          end
        end
      end
    end
    s_d.stat[DEV_STAT_IDX][CRC_ENABLED_BIT] = s_q.crcen_s;
    if (s_q.csn_s && !rise) begin
      s_d.shadow = s_q.stat;
    end
    for (int i = 0; i < NUM_STAT; i++) begin
      s_d.sum[i] = |s_q.shadow[i];
    end
    s_d.sum[DEV_STAT_IDX] = |(s_q.shadow[DEV_STAT_IDX] & ~DEV_SUMMARY_EXCL);
    s_d.sum[7] = s_q.shadow[DEV_STAT_IDX][CRC_FAIL_BIT]
      | s_q.shadow[DEV_STAT_IDX][CMD_REJECT_BIT];
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_q <= '0;
      s_q.csn_m <= 1'b1;
      s_q.csn_s <= 1'b1;
      s_q.csn_p <= 1'b1;
      s_q.rstl_m <= 1'b1;
      s_q.rstl_s <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign cfg_write = s_q.cfg;
  assign frame_error = s_q.err;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain. Select high clears the shift and output state; the snapshot is cleared only
  // by reset, so a falling edge outside a frame toggles its sequence bit. The system side reads the
  // snapshot only after select has risen and passed its synchroniser, when
  // no serial edges arrive and the snapshot is stable.

  logic link_clr;
  logic [6:0] laddr;
  logic [15:0] payload;
  logic [23:0] body;

  assign link_clr = reset | csn_n;
  assign status8 = {s_q.sum[7:1], s_q.sum[0] | s_q.err};

  always_comb begin
    l_d = l_q;
    laddr = {sdi, l_q.rx[5:0]};
    payload = '0;
    body = '0;
    if (l_q.cnt < FRAME_CLOCKS) begin
      l_d.rx[l_q.cnt[4:0]] = sdi;
    end
    if (l_q.cnt != COUNT_SAT) begin
      l_d.cnt = l_q.cnt + 6'd1;
    end
    if (l_q.cnt == ADDR_LAST_BIT) begin
      if (!laddr[6]) begin
        payload = s_q.ctrl[laddr[5:0]];
      // The full offset is compared so that unmapped addresses read zero.
      end else if (laddr >= STAT_BASE && (laddr - STAT_BASE) < 7'(NUM_STAT)) begin
        payload = s_q.shadow[3'(laddr - STAT_BASE)];
      end
      body = {payload, status8};
      l_d.tx = {s_q.crcen_s ? scfc_crc8(body) : FILLER_TX, body};
    end
    n_d = n_q;
    n_d.seq = (l_q.cnt == '0) ? ~n_q.seq : n_q.seq;
    n_d.cnt = l_d.cnt;
    n_d.word = l_d.rx;
  end

  always_ff @(negedge spi_clock or posedge link_clr) begin
    if (link_clr) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  always_ff @(negedge spi_clock or posedge reset) begin
    if (reset) begin
      n_q <= '0;
    end else begin
      n_q <= n_d;
    end
  end

  always_comb begin
    p_d = p_q;
    p_d.first = 1'b1;
    if (p_q.idx != 5'd31) begin
      p_d.idx = p_q.idx + 5'd1;
    end
    p_d.sdo = (p_d.idx < 5'd8) ? status8[p_d.idx[2:0]] : l_q.tx[p_d.idx];
  end

  always_ff @(posedge spi_clock or posedge link_clr) begin
    if (link_clr) begin
      p_q <= '0;
    end else begin
      p_q <= p_d;
    end
  end

  // Bit 0 must stand before any rising edge, so it comes from the system side.
  assign sdo_o = !s_q.rstl_s | (p_q.first ? p_q.sdo : status8[0]);
  assign sdo_oe = !csn_n && s_q.spi_on;

endmodule

/* design/scfc_pkg.sv */
// Constants, types and the checksum function of the serial frame checker.
// Assumes one system clock domain plus the serial clock of the host link.
//
// Notes on behaviour
// - Clock count not zero or 32 flags frame error.
// - Miscounted frame is discarded, nothing executed.
// - Serial clock high at select edge: frame error.
// - Error shows on SDO before first rising edge.
// - Frame overlapping low reset line flags frame error.
// - Reset line low forces SDO high.
// - Bits 6..0 address, bit 7 selector, 23..8 payload.
// - Status bits clear only by host clear access; the checksum-enabled bit follows the strap.
// - Restart mode: frames ignored completely.
// - Status same frame; writes apply at select rise.
// - Stop mode: mode-to-normal, watchdog, status only.
// - Late events latched, reported next frame.
// - Summary bits 0..6 OR each status register.
// - Bit 5 excludes two bits; bit 7 fail OR.
// - Checksum 0x2F poly, init FF, xor FF, bits 31..24.
// - Checksum covers bits 23..0 both directions.
// - Response payload is stored register content.
// - Bad checksum or bad filler sets checksum fail.
// - Checking off: host sends A5, device answers 5A.
// - Device status read skips check; enable bit read-only.
// - Sample on falling, shift on rising, tristate idle.
// - Link on in init, normal, stop modes only.
// - Rejected write ignored, sets command-reject flag.

package scfc_pkg;

  localparam int FRAME_BITS = 32;
  localparam logic [5:0] FRAME_CLOCKS = 6'd32;
  localparam logic [5:0] COUNT_SAT = 6'd33;
  localparam logic [5:0] ADDR_LAST_BIT = 6'd6;
  localparam int CTRL_DEPTH = 64;
  localparam int NUM_STAT = 7;
  localparam logic [6:0] STAT_BASE = 7'h40;
  localparam logic [6:0] DEV_STAT_ADDR = 7'h45;
  localparam int DEV_STAT_IDX = 5;
  localparam logic [6:0] MODE_CTRL_ADDR = 7'h01;
  localparam logic [6:0] WDOG_CTRL_ADDR = 7'h03;
  localparam logic [2:0] MODE_REQ_NORMAL = 3'h1;

  // Device status field positions.
  localparam int CRC_FAIL_BIT = 0;
  localparam int CMD_REJECT_BIT = 1;
  localparam int CRC_ENABLED_BIT = 2;
  localparam int SOFTWARE_EVENT_BIT = 3;
  localparam logic [15:0] DEV_SUMMARY_EXCL = 16'h000C;

  localparam logic [7:0] CRC_POLY = 8'h2F;
  localparam logic [7:0] CRC_INIT = 8'hFF;
  localparam logic [7:0] CRC_XOR = 8'hFF;
  localparam logic [7:0] FILLER_RX = 8'hA5;
  localparam logic [7:0] FILLER_TX = 8'h5A;

  typedef enum logic [2:0] {
    MODE_INIT, MODE_NORMAL, MODE_STOP, MODE_SLEEP, MODE_RESTART, MODE_FAILSAFE
  } scfc_mode_t;

  typedef struct packed {
    logic valid;
    logic [6:0] addr;
    logic [15:0] data;
  } scfc_cfg_write_t;

  typedef struct packed {
    logic csn_m;
    logic csn_s;
    logic csn_p;
    logic sclk_m;
    logic sclk_s;
    logic rstl_m;
    logic rstl_s;
    logic crcen_m;
    logic crcen_s;
    logic last_seq;
    logic frame_rst;
    logic clk_fall_err;
    logic err;
    logic spi_on;
    logic [7:0] sum;
    logic [NUM_STAT-1:0][15:0] stat;
    logic [NUM_STAT-1:0][15:0] shadow;
    logic [CTRL_DEPTH-1:0][15:0] ctrl;
    scfc_cfg_write_t cfg;
  } scfc_sys_t;

  typedef struct packed {
    logic [5:0] cnt;
    logic [31:0] rx;
    logic [31:0] tx;
  } scfc_shift_t;

  typedef struct packed {
    logic seq;
    logic [5:0] cnt;
    logic [31:0] word;
  } scfc_snap_t;

  typedef struct packed {
    logic first;
    logic [4:0] idx;
    logic sdo;
  } scfc_out_t;

  // Bytes in order bits 7..0, 15..8, 23..16, each most significant bit first.
  function automatic logic [7:0] scfc_crc8(input logic [23:0] w);
    logic [7:0] c;
    logic [23:0] s;
    logic fb;
    c = CRC_INIT;
    s = {w[7:0], w[15:8], w[23:16]};
    for (int i = 23; i >= 0; i--) begin
      fb = c[7] ^ s[i];
      c = {c[6:0], 1'b0};
      if (fb) begin
        c = c ^ CRC_POLY;
      end
    end
    return c ^ CRC_XOR;
  endfunction

endpackage

/* tb/scfc_chk.sv */
// Port checker of the serial frame checker.
// Assumes binding to every instance of scfc_frame_check.
`timescale 1ns/100ps
module scfc_chk
  import scfc_pkg::*;
(
  // Watched ports
  input wire logic clock,
  input wire logic reset,
  input wire scfc_mode_t device_mode,
  input wire logic device_reset_line_n,
  input wire logic csn_n,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  input wire scfc_cfg_write_t cfg_write,
  input wire logic frame_error
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  chk_oe_idle: assert property (csn_n |-> !sdo_oe) else $error("sdo driven");
  chk_oe_mode:
    assert property (sdo_oe |-> $past(device_mode) inside {MODE_INIT, MODE_NORMAL, MODE_STOP})
    else $error("link on in off mode");
  chk_rst_sdo: assert property ((!device_reset_line_n)[*4] |-> sdo_o) else $error("sdo low");
  chk_err_sdo:
    assert property (frame_error && !csn_n && $past(csn_n) |-> sdo_o) else $error("err not shown");
  chk_err_idle:
    assert property ($changed(frame_error) |-> csn_n && $past(csn_n, 2))
    else $error("err moved in frame");
  chk_err_nowr: assert property (cfg_write.valid |-> !frame_error) else $error("bad frame ran");
  chk_cfg_pulse:
    assert property (cfg_write.valid |-> csn_n ##1 !cfg_write.valid) else $error("write pulse");
  chk_cfg_addr:
    assert property (cfg_write.valid |-> cfg_write.addr < STAT_BASE) else $error("write addr");
  chk_cfg_stop:
    assert property (cfg_write.valid && device_mode == MODE_STOP |-> cfg_write.addr ==
      WDOG_CTRL_ADDR || cfg_write.addr == MODE_CTRL_ADDR && cfg_write.data[2:0] ==
      MODE_REQ_NORMAL) else $error("stop write");
endmodule
bind scfc_frame_check scfc_chk u_chk (.clock(clock), .reset(reset), .device_mode(device_mode),
  .device_reset_line_n(device_reset_line_n), .csn_n(csn_n), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
  .cfg_write(cfg_write), .frame_error(frame_error));

/* tb/scfc_frame_check_tb.sv */
// Self-checking bench of the serial frame checker.
// Assumes the host model and the bound port checker.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end

module scfc_frame_check_tb
  import scfc_pkg::*;
;
  logic clock = 1'b0;
  logic reset = 1'b1;
  scfc_mode_t device_mode = MODE_INIT;
  logic [NUM_STAT-1:0][15:0] stat_event = '0;
  logic device_reset_line_n = 1'b1;
  logic crc_enable_strap = 1'b0;
  logic spi_clock, csn_n, sdi, sdo_o, sdo_oe, frame_error;
  wire sdo = sdo_oe ? sdo_o : 1'bz;
  logic [31:0] rx;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;

  always #25 clock = ~clock;

  scfc_frame_check DUT (.clock(clock), .reset(reset), .device_mode(device_mode),
    .stat_event(stat_event), .device_reset_line_n(device_reset_line_n),
    .crc_enable_strap(crc_enable_strap), .spi_clock(spi_clock), .csn_n(csn_n), .sdi(sdi),
    .sdo_o(sdo_o), .sdo_oe(sdo_oe), .cfg_write(), .frame_error(frame_error));
  scfc_host u_host (.spi_clock(spi_clock), .csn_n(csn_n), .sdi(sdi), .sdo(sdo));

  //////////////////////////////////////////////////////////////
  function automatic logic [7:0] crc(input logic [23:0] w);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 0; i < 24; i++) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[(i / 8) * 8 + 7 - i % 8]) ? 8'h2F : 8'h00);
    end
    return ~c;
  endfunction

  task automatic fr(input logic [7:0] a, input logic [15:0] d, input int n = 32, input bit bad = 0,
    input bit hi = 0);
    logic [23:0] b;
    b = {d, a};
    u_host.xfer({(crc_enable_strap ? crc(b) : 8'hA5) ^ {8{bad}}, b}, n, hi, rx);
  endtask

  task automatic set_mode(input scfc_mode_t m);
    @(negedge clock);
    device_mode = m;
  endtask

  task automatic t_write;
    fr(8'h90, 16'h1234);
    fr(8'h90, 16'hABCD);
    `CHK("old payload", 16'h1234, rx[23:8])
    `CHK("filler", 8'h5A, rx[31:24])
    fr(8'h10, 16'h0000);
    `CHK("new payload", 16'hABCD, rx[23:8])
    `CHK("summary", 8'h00, rx[7:0])
    $display("done write");
  endtask

  task automatic t_frame_err;
    set_mode(MODE_NORMAL);
    fr(8'h90, 16'h5555, 31);
    `CHK("err count", 1'b1, frame_error)
    fr(8'h00, 16'h0000, 0);
    `CHK("err bit", 1'b1, rx[0])
    fr(8'h10, 16'h0000, 32, 0, 1);
    `CHK("discarded", 16'hABCD, rx[23:8])
    `CHK("err clock high", 1'b1, frame_error)
    @(negedge clock);
    device_reset_line_n = 1'b0;
    fr(8'h10, 16'h0000);
    `CHK("sdo high", 32'hFFFFFFFF, rx)
    `CHK("err reset line", 1'b1, frame_error)
    @(negedge clock);
    device_reset_line_n = 1'b1;
    fr(8'h10, 16'h0000);
    `CHK("err cleared", 1'b0, frame_error)
    $display("done frame errors");
  endtask

  task automatic t_modes;
    scfc_mode_t off[3] = '{MODE_SLEEP, MODE_RESTART, MODE_FAILSAFE};
    foreach (off[i]) begin
      set_mode(off[i]);
      fr(8'h90, 16'h1111, 31);
      `CHK("off no err", 1'b0, frame_error)
    end
    set_mode(MODE_STOP);
    fr(8'h90, 16'h7777);
    fr(8'h10, 16'h0000);
    `CHK("stop ignored", 16'hABCD, rx[23:8])
    `CHK("reject", 1'b1, rx[7])
    fr(8'hC5, 16'h0000);
    `CHK("sticky", 1'b1, rx[7])
    fr(8'h81, 16'h0001);
    `CHK("reject clear", 1'b0, rx[7])
    fr(8'h01, 16'h0000);
    `CHK("stop mode write", 3'h1, rx[10:8])
    set_mode(MODE_NORMAL);
    $display("done modes");
  endtask

  task automatic t_crc;
    @(negedge clock);
    crc_enable_strap = 1'b1;
    fr(8'h90, 16'h2468);
    `CHK("rsp crc", crc(rx[23:0]), rx[31:24])
    fr(8'h90, 16'h1357, 32, 1);
    fr(8'h45, 16'h0000, 32, 1);
    `CHK("crc fail", 2'h3, {rx[7], rx[8 + CRC_FAIL_BIT]})
    `CHK("crc on bit", 1'b1, rx[8 + CRC_ENABLED_BIT])
    fr(8'hC5, 16'h0000);
    fr(8'h45, 16'h0000, 32, 1);
    fr(8'h10, 16'h0000);
    `CHK("bad write", 16'h2468, rx[23:8])
    `CHK("read no fail", 1'b0, rx[7])
    @(negedge clock);
    crc_enable_strap = 1'b0;
    $display("done crc");
  endtask

  task automatic t_status;
    @(negedge clock);
    for (int i = 0; i < NUM_STAT; i++) begin
      stat_event[i] = (i == DEV_STAT_IDX) ? 16'h0008 : 16'h0001 << i;
    end
    @(negedge clock);
    stat_event = '0;
    fr(8'h41, 16'h0000);
    `CHK("summary", 8'h5F, rx[7:0])
    fr(8'h46, 16'h0000);
    `CHK("summary kept", 8'h5F, rx[7:0])
    `CHK("bridge", 16'h0040, rx[23:8])
    fr(8'h48, 16'h0000);
    `CHK("unmapped", 16'h0000, rx[23:8])
    for (int i = 0; i < NUM_STAT; i++) begin
      fr(8'(8'hC0 + i), 16'h0000);
    end
    // A thermal event arrives well after the seventh serial clock.
    fork
      fr(8'h40, 16'h0000);
      begin
        repeat (6) @(negedge clock);
        stat_event[1] = 16'h0004;
        @(negedge clock);
        stat_event = '0;
      end
    join
    `CHK("cleared", 8'h00, rx[7:0])
    fr(8'h40, 16'h0000);
    `CHK("late event", 8'h02, rx[7:0])
    $display("done status");
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      close_out;
    end
  end

  initial begin
    repeat (6) @(posedge clock);
    @(negedge clock);
    reset = 1'b0;
    repeat (4) @(negedge clock);
    t_write;
    t_frame_err;
    t_modes;
    t_crc;
    t_status;
    close_out;
  end
endmodule

/* tb/scfc_host.sv */
// Host model driving the serial link as master.
// Assumes a 6 ns serial clock that stands low between frames.
`timescale 1ns/100ps
module scfc_host (
  // Serial link
  output logic spi_clock,
  output logic csn_n,
  output logic sdi,
  input wire logic sdo
);
  initial begin
    spi_clock = 1'b0;
    csn_n = 1'b1;
    sdi = 1'b0;
  end
  // The long select waits give the device's synchronisers time to settle.
  task automatic xfer(input logic [31:0] w, input int n, input bit hi, output logic [31:0] rx);
    csn_n = 1'b0;
    #200;
    rx[0] = sdo;
    for (int k = 0; k < n; k++) begin
      sdi = w[k];
      #2;
      rx[k] = sdo;
      spi_clock = 1'b1;
      #3;
      spi_clock = 1'b0;
      #1;
    end
    spi_clock = hi;
    #10;
    // A high clock is held across the select edge for several system clocks,
    // since the device only sees it through a sampling synchroniser.
    if (hi) begin
      #200;
    end
    csn_n = 1'b1;
    #5;
    if (hi) begin
      #200;
    end
    spi_clock = 1'b0;
    sdi = ~sdi;
    #400;
  endtask
endmodule
